// [logic/ucb_pkg.sv]
package ucb_pkg;

   // Register location: I/O space and data space views
   localparam logic [7:0] CTRL_B_IO_ADDR = 8'h0a;
   localparam logic [7:0] CTRL_B_DS_ADDR = 8'h2a;
   localparam logic [7:0] CTRL_B_RESET = 8'h00;
   // Bit 1 is read-only and is never stored from a write
   localparam logic [7:0] CTRL_B_WR_MASK = 8'hfd;

   // Field positions
   localparam int BIT_RX_DONE_IRQ_EN = 7;
   localparam int BIT_TX_DONE_IRQ_EN = 6;
   localparam int BIT_BUF_EMPTY_IRQ_EN = 5;
   localparam int BIT_RECEIVER_ON = 4;
   localparam int BIT_TRANSMITTER_ON = 3;
   localparam int BIT_CHAR_SIZE_MSB = 2;
   localparam int BIT_RX_NINTH = 1;
   localparam int BIT_TX_NINTH = 0;

   // Character size codes {msb, low[1:0]}
   localparam logic [2:0] SIZE_5 = 3'h0;
   localparam logic [2:0] SIZE_6 = 3'h1;
   localparam logic [2:0] SIZE_7 = 3'h2;
   localparam logic [2:0] SIZE_8 = 3'h3;
   localparam logic [2:0] SIZE_9 = 3'h7;

   // Bit timing
   localparam int CLK_HZ = 50000000;
   localparam int BAUD_HZ = 9600;
   localparam int BIT_CYCLES_DEF = CLK_HZ / BAUD_HZ;
   localparam int BIT_CNT_W = 16;

   // Frame shifter: start + up to 9 data + stop
   localparam int FRAME_W = 11;
   localparam int FIFO_DEPTH = 2;

   typedef struct packed {
      logic parity_err;
      logic frame_err;
      logic [8:0] data;
   } ucb_rx_entry_t;

   typedef enum logic [1:0] {
      TX_IDLE = 2'b01,
      TX_SHIFT = 2'b10
   } ucb_tx_state_t;

   function automatic logic [3:0] ucb_data_bits(input logic [2:0] code);
      case (code)
         SIZE_5: ucb_data_bits = 4'h5;
         SIZE_6: ucb_data_bits = 4'h6;
         SIZE_7: ucb_data_bits = 4'h7;
         SIZE_9: ucb_data_bits = 4'h9;
         default: ucb_data_bits = 4'h8;
      endcase
   endfunction

endpackage

// [logic/ucb_fifo2.sv]
`timescale 1ns/1ps
`default_nettype none
module ucb_fifo2 #(
   parameter int WIDTH = 11
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic flush,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   logic [WIDTH-1:0] mem [ucb_pkg::FIFO_DEPTH];
   logic wr_ptr;
   logic rd_ptr;
   logic [1:0] count;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;

   assign in_ready = (count != 2'h2);
   assign out_valid = (count != 2'h0);
   assign out_data = mem[rd_ptr];

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         count <= 2'h0;
      end else if (flush) begin
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         count <= 2'h0;
      end else begin
         wr_ptr <= wr_ptr ^ push;
         rd_ptr <= rd_ptr ^ pop;
         count <= count + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule
`default_nettype wire

// [logic/ucb_tx_shift.sv]
`timescale 1ns/1ps
`default_nettype none
module ucb_tx_shift (
   input wire logic clk,
   input wire logic nrst,
   input wire logic bit_tick,
   input wire logic [3:0] data_bits,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [8:0] in_data,
   output logic txd,
   output logic busy,
   output logic done
);
   ucb_pkg::ucb_tx_state_t state;
   logic [ucb_pkg::FRAME_W-1:0] shreg;
   logic [3:0] left;
   logic [ucb_pkg::FRAME_W-1:0] frame;
   logic [8:0] keep;

   // Unused high data bits become idle ones, so the stop bit follows
   assign keep = 9'h1ff >> (4'h9 - data_bits);
   assign frame = {1'b1, (in_data & keep) | ~keep, 1'b0};
   assign in_ready = (state == ucb_pkg::TX_IDLE) && bit_tick;
   assign busy = (state == ucb_pkg::TX_SHIFT);
   assign txd = busy ? shreg[0] : 1'b1;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state <= ucb_pkg::TX_IDLE;
         shreg <= '1;
         left <= 4'h0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         case (state)
            ucb_pkg::TX_IDLE: begin
               if (in_valid && bit_tick) begin
                  shreg <= frame;
                  left <= data_bits + 4'h1;
                  state <= ucb_pkg::TX_SHIFT;
               end
            end
            ucb_pkg::TX_SHIFT: begin
               if (bit_tick) begin
                  shreg <= {1'b1, shreg[ucb_pkg::FRAME_W-1:1]};
                  left <= left - 4'h1;
                  if (left == 4'h0) begin
                     state <= ucb_pkg::TX_IDLE;
                     done <= 1'b1;
                  end
               end
            end
            default: state <= ucb_pkg::TX_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

// [logic/ucb_serial_control.sv]
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Receive irq needs enable, global, flag.
// - Transmit irq needs enable, global, flag.
// - Empty irq needs enable, global, flag.
// - Bit 4 enables receiver, owns RxD.
// - Receiver off flushes buffer and errors.
// - Bit 3 enables transmitter, owns TxD.
// - Transmitter drains buffer and shifter first.
// - Idle disabled transmitter releases TxD pin.
// - Bit 2 is top character size bit.
// - At 0x0A/0x2A, reset zero, bit1 read-only.
module ucb_serial_control #(
   parameter int BIT_CYCLES = ucb_pkg::BIT_CYCLES_DEF
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [7:0] io_addr,
   input wire logic io_space,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [7:0] io_wdata,
   output logic [7:0] io_rdata,
   input wire logic global_irq_en,
   input wire logic [1:0] char_size_low,
   input wire logic tx_wr,
   input wire logic [7:0] tx_wr_data,
   input wire logic tx_done_clr,
   input wire logic rx_char_valid,
   input wire logic [8:0] rx_char_data,
   input wire logic rx_char_frame_err,
   input wire logic rx_char_parity_err,
   input wire logic rx_rd,
   output logic [7:0] rx_data,
   output logic rx_done_flag,
   output logic tx_done_flag,
   output logic buf_empty_flag,
   output logic frame_error_flag,
   output logic overrun_flag,
   output logic parity_error_flag,
   output logic rx_done_irq,
   output logic tx_done_irq,
   output logic buf_empty_irq,
   output logic rxd_owned,
   output logic txd_out,
   output logic txd_oe,
   output logic char_size_msb
);
   logic [7:0] ctrl;
   logic [ucb_pkg::BIT_CNT_W-1:0] bit_cnt;
   logic bit_tick;

   wire hit = io_space ? (io_addr == ucb_pkg::CTRL_B_IO_ADDR)
                       : (io_addr == ucb_pkg::CTRL_B_DS_ADDR);
   wire ctrl_wr = io_wr && hit;
   wire receiver_on = ctrl[ucb_pkg::BIT_RECEIVER_ON];
   wire transmitter_on = ctrl[ucb_pkg::BIT_TRANSMITTER_ON];
   wire [2:0] size_code = {ctrl[ucb_pkg::BIT_CHAR_SIZE_MSB],
                           char_size_low};
   wire nine_bit = (size_code == ucb_pkg::SIZE_9);
   wire [3:0] data_bits = ucb_pkg::ucb_data_bits(size_code);

   // Transmit path
   wire txq_in_ready;
   wire txq_out_valid;
   wire [8:0] txq_out_data;
   wire sh_ready;
   wire sh_txd;
   wire sh_busy;
   wire sh_done;
   wire tx_push = tx_wr && transmitter_on;
   wire [8:0] tx_word = {ctrl[ucb_pkg::BIT_TX_NINTH] & nine_bit,
                         tx_wr_data};
   // Stays active after disable until buffer and shifter are empty
   wire tx_active = transmitter_on || txq_out_valid || sh_busy;

   // Receive path
   ucb_pkg::ucb_rx_entry_t rx_in;
   ucb_pkg::ucb_rx_entry_t rx_head;
   wire rxq_in_ready;
   wire rxq_out_valid;
   wire rx_push = rx_char_valid && receiver_on;
   wire rx_pop = rx_rd && rxq_out_valid;
   wire rx_lost = rx_push && !rxq_in_ready;
   wire rx_ninth = nine_bit && rxq_out_valid && rx_head.data[8];
   wire [7:0] read_view = {ctrl[7:2], rx_ninth, ctrl[0]};

   assign rx_in.parity_err = rx_char_parity_err;
   assign rx_in.frame_err = rx_char_frame_err;
   assign rx_in.data = rx_char_data;

   // Bit-rate divider: one-cycle tick per bit time
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         bit_cnt <= '0;
         bit_tick <= 1'b0;
      end else begin
         bit_tick <= (bit_cnt == ucb_pkg::BIT_CNT_W'(BIT_CYCLES - 1));
         if (bit_cnt == ucb_pkg::BIT_CNT_W'(BIT_CYCLES - 1)) begin
            bit_cnt <= '0;
         end else begin
            bit_cnt <= bit_cnt + 1'b1;
         end
      end
   end

   ucb_fifo2 #(
      .WIDTH(9)
   ) u_txq (
      .clk(clk),
      .nrst(nrst),
      .flush(1'b0),
      .in_valid(tx_push),
      .in_ready(txq_in_ready),
      .in_data(tx_word),
      .out_valid(txq_out_valid),
      .out_ready(sh_ready),
      .out_data(txq_out_data)
   );

   ucb_tx_shift u_shift (
      .clk(clk),
      .nrst(nrst),
      .bit_tick(bit_tick),
      .data_bits(data_bits),
      .in_valid(txq_out_valid),
      .in_ready(sh_ready),
      .in_data(txq_out_data),
      .txd(sh_txd),
      .busy(sh_busy),
      .done(sh_done)
   );

   ucb_fifo2 #(
      .WIDTH($bits(ucb_pkg::ucb_rx_entry_t))
   ) u_rxq (
      .clk(clk),
      .nrst(nrst),
      .flush(!receiver_on),
      .in_valid(rx_push),
      .in_ready(rxq_in_ready),
      .in_data(rx_in),
      .out_valid(rxq_out_valid),
      .out_ready(rx_rd),
      .out_data(rx_head)
   );

   // Control register and read port
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ctrl <= ucb_pkg::CTRL_B_RESET;
         io_rdata <= 8'h00;
      end else begin
         if (ctrl_wr) begin
            ctrl <= io_wdata & ucb_pkg::CTRL_B_WR_MASK;
         end
         if (io_rd) begin
            io_rdata <= hit ? read_view : 8'h00;
         end
      end
   end

   // Status flags; a set in the clear cycle wins
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tx_done_flag <= 1'b0;
         overrun_flag <= 1'b0;
      end else begin
         if (sh_done && !txq_out_valid) begin
            tx_done_flag <= 1'b1;
         end else if (tx_done_clr) begin
            tx_done_flag <= 1'b0;
         end
         if (!receiver_on) begin
            overrun_flag <= 1'b0;
         end else if (rx_lost) begin
            overrun_flag <= 1'b1;
         end else if (rx_pop) begin
            overrun_flag <= 1'b0;
         end
      end
   end

   // Registered views of the receive head, receive buffer state and transmit buffer space
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rx_done_flag <= 1'b0;
         buf_empty_flag <= 1'b0;
         frame_error_flag <= 1'b0;
         parity_error_flag <= 1'b0;
         rx_data <= 8'h00;
      end else begin
         rx_done_flag <= rxq_out_valid;
         buf_empty_flag <= txq_in_ready;
         frame_error_flag <= rxq_out_valid && rx_head.frame_err;
         parity_error_flag <= rxq_out_valid && rx_head.parity_err;
         rx_data <= rxq_out_valid ? rx_head.data[7:0] : 8'h00;
      end
   end

   // Interrupt requests
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rx_done_irq <= 1'b0;
         tx_done_irq <= 1'b0;
         buf_empty_irq <= 1'b0;
      end else begin
         rx_done_irq <= ctrl[ucb_pkg::BIT_RX_DONE_IRQ_EN] && global_irq_en
                        && rx_done_flag;
         tx_done_irq <= ctrl[ucb_pkg::BIT_TX_DONE_IRQ_EN] && global_irq_en
                        && tx_done_flag;
         buf_empty_irq <= ctrl[ucb_pkg::BIT_BUF_EMPTY_IRQ_EN]
                          && global_irq_en && buf_empty_flag;
      end
   end

   // Pin ownership
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rxd_owned <= 1'b0;
         txd_oe <= 1'b0;
         txd_out <= 1'b1;
         char_size_msb <= 1'b0;
      end else begin
         rxd_owned <= receiver_on;
         txd_oe <= tx_active;
         txd_out <= tx_active ? sh_txd : 1'b1;
         char_size_msb <= ctrl[ucb_pkg::BIT_CHAR_SIZE_MSB];
      end
   end
endmodule
`default_nettype wire

// [verif/ucb_serial_control_props.sv]
`timescale 1ns/1ps
`default_nettype none
module ucb_serial_control_props (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [7:0] io_addr,
   input wire logic io_space,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [7:0] io_wdata,
   input wire logic [7:0] io_rdata,
   input wire logic global_irq_en,
   input wire logic rx_done_flag,
   input wire logic tx_done_flag,
   input wire logic buf_empty_flag,
   input wire logic frame_error_flag,
   input wire logic rx_done_irq,
   input wire logic tx_done_irq,
   input wire logic buf_empty_irq,
   input wire logic rxd_owned,
   input wire logic txd_oe,
   input wire logic char_size_msb
);
   logic [7:0] sh;
   wire logic hit = io_space ? io_addr == ucb_pkg::CTRL_B_IO_ADDR :
      io_addr == ucb_pkg::CTRL_B_DS_ADDR;
   // Shadow of the control register as software wrote it
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sh <= ucb_pkg::CTRL_B_RESET;
      end else if (io_wr && hit) begin
         sh <= io_wdata & ucb_pkg::CTRL_B_WR_MASK;
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   sequence s_rx_clear;
      !rx_done_flag && !frame_error_flag;
   endsequence
   chk_rx_irq_gate: assert property (
      ##1 rx_done_irq == $past(sh[7] & global_irq_en & rx_done_flag))
      else $error("receive irq gating wrong");
   chk_tx_irq_gate: assert property (
      ##1 tx_done_irq == $past(sh[6] & global_irq_en & tx_done_flag))
      else $error("transmit irq gating wrong");
   chk_be_irq_gate: assert property (
      ##1 buf_empty_irq == $past(sh[5] & global_irq_en & buf_empty_flag))
      else $error("empty irq gating wrong");
   chk_rx_pin_own: assert property (
      $changed(sh[4]) |-> ##[0:1] rxd_owned == sh[4])
      else $error("receive pin ownership wrong");
   chk_rx_flush: assert property (
      $fell(sh[4]) |-> ##[1:2] s_rx_clear)
      else $error("receive buffer not flushed");
   chk_tx_pin_own: assert property (
      $rose(sh[3]) |-> ##[0:2] txd_oe)
      else $error("transmit pin not taken");
   chk_tx_release: assert property (
      $fell(txd_oe) |-> !sh[3] && !$past(sh[3]))
      else $error("transmit pin released while enabled");
   chk_size_top: assert property (
      $changed(sh[2]) |-> ##[0:1] char_size_msb == sh[2])
      else $error("size bit not followed");
   chk_reg_read: assert property (
      io_rd && hit |=> io_rdata[7:2] == $past(sh[7:2]) &&
         io_rdata[0] == $past(sh[0]))
      else $error("control read value wrong");
   chk_unmapped_rd: assert property (
      io_rd && !hit |=> io_rdata == 8'h00)
      else $error("unmapped read not zero");
endmodule
bind ucb_serial_control ucb_serial_control_props i_props (.clk, .nrst,
   .io_addr, .io_space, .io_wr, .io_rd, .io_wdata, .io_rdata, .global_irq_en,
   .rx_done_flag, .tx_done_flag, .buf_empty_flag, .frame_error_flag,
   .rx_done_irq, .tx_done_irq, .buf_empty_irq, .rxd_owned, .txd_oe,
   .char_size_msb);
`default_nettype wire

// [verif/ucb_remote_node.sv]
`timescale 1ns/1ps
`default_nettype none
module ucb_remote_node #(
   parameter int BIT_CYCLES = 4
) (
   input wire logic clk,
   input wire logic txd,
   input wire logic [3:0] nbits,
   output logic rx_valid,
   output logic [8:0] rx_data,
   output logic rx_fe,
   output logic rx_pe
);
   logic [8:0] got;
   int frames;
   initial begin
      rx_valid = 1'b0;
      rx_data = 9'h000;
      rx_fe = 1'b0;
      rx_pe = 1'b0;
      got = 9'h000;
      frames = 0;
   end
   // Mid-bit sampling keeps clear of the line's transition edges
   always begin
      @(negedge txd);
      repeat (BIT_CYCLES / 2) @(posedge clk);
      for (int i = 0; i < int'(nbits); i++) begin
         repeat (BIT_CYCLES) @(posedge clk);
         got[i] = txd;
      end
      repeat (BIT_CYCLES) @(posedge clk);
      if (txd === 1'b1) begin
         frames++;
      end
   end
   task automatic send(input logic [8:0] d, input logic fe, input logic pe);
      @(negedge clk);
      rx_valid = 1'b1;
      rx_data = d;
      rx_fe = fe;
      rx_pe = pe;
      @(negedge clk);
      rx_valid = 1'b0;
      rx_data = ~d;
      rx_fe = ~fe;
      rx_pe = ~pe;
   endtask
endmodule
`default_nettype wire

// [verif/ucb_serial_control_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module ucb_serial_control_tb;
   logic clk, nrst, io_space, io_wr, io_rd, global_irq_en, tx_wr, tx_done_clr;
   logic rx_rd, rx_char_valid, rx_char_frame_err, rx_char_parity_err;
   logic [7:0] io_addr, io_wdata, io_rdata, tx_wr_data, rx_data;
   logic [8:0] rx_char_data;
   logic [1:0] char_size_low;
   logic rx_done_flag, tx_done_flag, buf_empty_flag, frame_error_flag;
   logic overrun_flag, parity_error_flag, rx_done_irq, tx_done_irq;
   logic buf_empty_irq, rxd_owned, txd_out, txd_oe, char_size_msb;
   int error_cnt = 0;
   int comparisons = 0;
   int held;
   // Idle level of the pulled-up line once the pin is released
   wire logic line = txd_oe ? txd_out : 1'b1;
   ucb_serial_control #(.BIT_CYCLES(4)) i_ucb_serial_control (.clk, .nrst,
      .io_addr, .io_space, .io_wr, .io_rd, .io_wdata, .io_rdata,
      .global_irq_en, .char_size_low, .tx_wr, .tx_wr_data, .tx_done_clr,
      .rx_char_valid, .rx_char_data, .rx_char_frame_err, .rx_char_parity_err,
      .rx_rd, .rx_data, .rx_done_flag, .tx_done_flag, .buf_empty_flag,
      .frame_error_flag, .overrun_flag, .parity_error_flag, .rx_done_irq,
      .tx_done_irq, .buf_empty_irq, .rxd_owned, .txd_out, .txd_oe,
      .char_size_msb);
   ucb_remote_node #(.BIT_CYCLES(4)) i_ucb_remote_node (.clk, .txd(line),
      .nbits(4'h9), .rx_valid(rx_char_valid), .rx_data(rx_char_data),
      .rx_fe(rx_char_frame_err), .rx_pe(rx_char_parity_err));
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic sp, input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      io_space = sp;
      io_addr = a;
      io_wdata = d;
      io_wr = 1'b1;
      @(negedge clk);
      io_wr = 1'b0;
   endtask
   task automatic rdc(input logic sp, input logic [7:0] a, input logic [7:0] e);
      @(negedge clk);
      io_space = sp;
      io_addr = a;
      io_rd = 1'b1;
      @(negedge clk);
      io_rd = 1'b0;
      chk({8'h00, io_rdata}, {8'h00, e});
   endtask
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      repeat (3000) @(posedge clk);
      error_cnt++;
      finish_test();
   end
   initial begin
      {nrst, io_space, io_wr, io_rd, global_irq_en, tx_wr, tx_done_clr} = '0;
      {rx_rd, io_addr, io_wdata, tx_wr_data} = '0;
      char_size_low = 2'b11;
      repeat (8) @(negedge clk);
      nrst = 1'b1;
      rdc(1'b1, 8'h0a, 8'h00);
      rdc(1'b0, 8'h2a, 8'h00);
      rdc(1'b1, 8'h2a, 8'h00);
      $display("test reset_map done");
      wr(1'b1, 8'h0a, 8'hff);
      rdc(1'b0, 8'h2a, 8'hfd);
      chk({13'h0, char_size_msb, rxd_owned, txd_oe}, 16'h0007);
      global_irq_en = 1'b1;
      repeat (3) @(negedge clk);
      chk({13'h0, buf_empty_irq, tx_done_irq, rx_done_irq}, 16'h0004);
      wr(1'b0, 8'h2a, 8'hdf);
      repeat (3) @(negedge clk);
      chk({15'h0, buf_empty_irq}, 16'h0000);
      $display("test control_bits done");
      rdc(1'b1, 8'h0a, 8'hdd);
      i_ucb_remote_node.send(9'h1a5, 1'b1, 1'b1);
      repeat (3) @(negedge clk);
      chk({rx_done_flag, frame_error_flag, parity_error_flag, rx_done_irq,
         4'h0, rx_data}, 16'hf0a5);
      rdc(1'b1, 8'h0a, 8'hdf);
      i_ucb_remote_node.send(9'h011, 1'b0, 1'b0);
      i_ucb_remote_node.send(9'h022, 1'b0, 1'b0);
      repeat (3) @(negedge clk);
      chk({15'h0, overrun_flag}, 16'h0001);
      rx_rd = 1'b1;
      @(negedge clk);
      rx_rd = 1'b0;
      repeat (2) @(negedge clk);
      chk({6'h0, overrun_flag, frame_error_flag, rx_data}, 16'h0011);
      wr(1'b1, 8'h0a, 8'hcf);
      repeat (3) @(negedge clk);
      chk({11'h0, rx_done_flag, frame_error_flag, parity_error_flag,
         overrun_flag, rxd_owned}, 16'h0000);
      $display("test receive_flush done");
      @(negedge clk);
      tx_wr_data = 8'h3c;
      tx_wr = 1'b1;
      @(negedge clk);
      tx_wr_data = 8'hc3;
      @(negedge clk);
      tx_wr = 1'b0;
      wr(1'b1, 8'h0a, 8'hc5);
      held = 1;
      for (int i = 0; i < 400 && i_ucb_remote_node.frames < 2; i++) begin
         @(negedge clk);
         if (txd_oe !== 1'b1) begin
            held = 0;
         end
      end
      chk(16'(held), 16'h0001);
      chk({7'h0, i_ucb_remote_node.got}, 16'h01c3);
      repeat (8) @(negedge clk);
      chk({13'h0, txd_oe, tx_done_flag, tx_done_irq}, 16'h0003);
      tx_done_clr = 1'b1;
      @(negedge clk);
      tx_done_clr = 1'b0;
      repeat (3) @(negedge clk);
      chk({14'h0, tx_done_flag, tx_done_irq}, 16'h0000);
      $display("test transmit_drain done");
      finish_test();
   end
endmodule
`default_nettype wire
